// ### rtl/sc_uart_defs.svh
// constants for the smart-card status, fifo and data-buffer section
`ifndef SC_UART_DEFS_SVH
`define SC_UART_DEFS_SVH

// host port addresses
`define SC_ADDR_TIMEOUT_CFG 4'h8
`define SC_ADDR_MIXED       4'hc
`define SC_ADDR_DATA        4'hd

// reset values
`define SC_FIFO_CTRL_RST    7'h00
`define SC_DATA_RST         8'h00
`define SC_SYNC_RST         7'h7f

// fifo control field positions
`define SC_FC_PEC_HI        6
`define SC_FC_PEC_LO        4
`define SC_FC_FTE_UPPER     3
`define SC_FC_FL_HI         2
`define SC_FC_FL_LO         0

// synchroniser bit positions
`define SC_PIN_CS           0
`define SC_PIN_RD           1
`define SC_PIN_WR           2
`define SC_PIN_PRES_A       3
`define SC_PIN_PRES_B       4
`define SC_PIN_AUX          5
`define SC_PIN_IO           6

// timing counts
`define SC_BUSY_CYCLES      2'd3
`define SC_TOC_FRACTIONS    2'd2
`define SC_BGT_T0_ETU       9'd16
`define SC_BGT_T1_ETU       9'd22
`define SC_GUARD_ETU        9'd12
`define SC_RELOAD_MIN_ETU   9'd14
`define SC_RETRY_ETU        9'd15
`define SC_PARITY_ETU       9'd9
`define SC_CHECK_ETU        9'd10
`define SC_END_ETU          9'd11
`define SC_ETU_SAT          9'h1ff
`define SC_MIN_ETU_LEN      16'h0002

`endif

// ### rtl/sc_uart_pkg.sv
// types of the smart-card status, fifo and data-buffer section
package sc_uart_pkg;
   // character engine states
   typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RETRY, ST_RX} engine_state_t;
endpackage

// ### rtl/fifo_mem_if.sv
// bundle between the fifo control logic and its storage
`timescale 1ns/100ps
`default_nettype none
interface fifo_mem_if #(parameter int WIDTH = 8, parameter int AW = 3);
   logic             wr_en;     // store one word
   logic [AW-1:0]    wr_addr;   // write slot
   logic [WIDTH-1:0] wr_data;   // word to store
   logic [AW-1:0]    rd_addr;   // slot presented on rd_data
   logic [WIDTH-1:0] rd_data;   // registered read word
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### rtl/rx_fifo_mem.sv
// receive fifo storage with registered read port
`timescale 1ns/100ps
`default_nettype none
module rx_fifo_mem #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 8
) (
   // clock
   input wire logic core_clk,
   // storage port
   fifo_mem_if.mem  port
);
   logic [WIDTH-1:0] mem_q [DEPTH];   // character slots
   logic [WIDTH-1:0] rd_q;            // read word register

   // write side
   always_ff @(posedge core_clk)
   begin
      if (port.wr_en)
         mem_q[port.wr_addr] <= port.wr_data;
   end

   // read word always follows the read slot, one cycle late
   always_ff @(posedge core_clk)
   begin
      rd_q <= mem_q[port.rd_addr];
   end

   assign port.rd_data = rd_q;
endmodule // rx_fifo_mem
`default_nettype wire

// ### rtl/smart_card_uart_status_fifo.sv
// status flags, receive fifo and data buffer of a smart-card uart
//
// Behaviour
// - clock switched flag shows selected card clock
// - fifo empty flag tracks stored character count
// - block guard counter restarts each start bit
// - control ready low three cycles after data access
// - timeout config write holds ready one-two fractions
// - synchronous mode forces control ready high
// - separate presence flags for card a, b
// - status bit mirrors auxiliary interrupt pin
// - tx empty flag set on three events
// - no tx empty after flagged last char
// - tx empty flag cleared on four events
// - t0 transmit retries at fifteen etu
// - zero limit: no retry, reload after 14
// - t0 receive parity error after limit+1
// - t1 sets parity error on any error
// - threshold needs both enables; upper reads zero
// - fifo depth is length field plus one
// - convention translated both directions for host
// - data read returns oldest stored character
// - synchronous mode uses bit zero only
// - transmit start waits for guard, previous char
// - tx empty set when direction goes transmit
// - flagged last char returns uart to receive
`timescale 1ns/100ps
`default_nettype none
`include "sc_uart_defs.svh"
module smart_card_uart_status_fifo
   import sc_uart_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // host parallel port
   input  wire logic       cs_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] rdata,
   // control bits held elsewhere in the uart
   input  wire logic       uart_reset_n,
   input  wire logic       direction_tx,
   input  wire logic       last_char_flag,
   input  wire logic       protocol_t1,
   input  wire logic       sync_mode,
   input  wire logic       convention_select,
   input  wire logic       threshold_enable_lower,
   input  wire logic       clock_switched_in,
   input  wire logic [7:0] etu_prescaler,
   input  wire logic [7:0] frac_cycles,
   input  wire logic [7:0] extra_guard_etu,
   // card side pins
   input  wire logic       card_a_present_pin,
   input  wire logic       card_b_present_pin,
   input  wire logic       aux_interrupt_input,
   input  wire logic       io_in,
   output logic            io_out,
   output logic            io_oe_n,
   // events and flags towards the rest of the uart
   output var  logic       last_char_clear,
   output var  logic       direction_clear,
   output var  logic       parity_error_event,
   output var  logic       overrun_event,
   output logic            fifo_threshold_en,
   output logic            tx_empty_rx_full_flag
);
   localparam int AW = $clog2(FIFO_DEPTH);

   // the length field can ask for eight slots
   if (FIFO_DEPTH < 8 || (1 << AW) != FIFO_DEPTH)
      $error("FIFO_DEPTH must be a power of two of at least 8");

   // same mapping both ways: inverse is inverted and msb first
   function automatic logic [7:0] convention_select_xlate(input logic [7:0] v, input logic direct);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
         r[i] = v[7 - i];
      return direct ? v : ~r;
   endfunction

   // line-level parity: even ones direct, odd ones inverse
   function automatic logic par_level(input logic [7:0] raw, input logic direct);
      return direct ? ^raw : ~^raw;
   endfunction

   logic            rst_all;          // hard reset or uart held in reset
   logic [6:0]      s1_q, s2_q, s3_q; // pin synchroniser stages
   logic [6:0]      lvl_q;            // agreed pin levels
   logic            rd_act, wr_act;   // host strobes active
   logic            rd_act_q, wr_act_q;
   logic            rd_end, wr_end;   // strobe rising edges
   logic [3:0]      addr_q;           // address of the running access
   logic [7:0]      wdata_q;          // data of the running access
   logic [6:0]      fctl_q;           // pec, upper threshold enable, length
   logic [1:0]      busy_q;           // control ready short busy count
   logic [1:0]      toc_wait_q;       // sub-etu fractions still to wait
   logic [7:0]      frac_q;           // fraction divider
   logic            sub_tick;
   logic            control_ready_flag;             // control ready
   logic [15:0]     etu_len;          // clock cycles per etu
   logic [15:0]     cyc_q;            // cycle inside current etu
   logic [8:0]      etu_n_q;          // etus since last start bit
   logic            etu_tick, mid;
   engine_state_t   state_q;
   logic            tx_pend_q;        // character loaded, not yet sent
   logic [7:0]      tx_raw_q;         // character in line order
   logic            lct_q;            // last-char flag caught at load
   logic            fail_q;           // previous character gave up
   logic            nak_seen_q;       // card flagged a parity error
   logic            nak_q;            // we flag a parity error
   logic [2:0]      perr_q;           // parity error / retry count
   logic [7:0]      rx_raw_q;         // received bits, line order
   logic            rx_par_q;
   logic            sync_bit_q;       // synchronous mode output level
   logic            start_tx, start_rx, retry_go, start_bit;
   logic            guard_ok, io_fall, io_prev_q;
   logic            wr_data_ok, rd_pop, tx_ok;
   logic            rx_store, rx_bad, fifo_full;
   logic [AW:0]     count_q;          // characters stored
   logic [AW-1:0]   wptr_q, rptr_q;
   logic [AW:0]     depth_eff;
   logic            dir_q, tbe_q;
   logic [8:0]      gap;

   fifo_mem_if #(.WIDTH(8), .AW(AW)) mem_bus ();

   rx_fifo_mem #(.DEPTH(FIFO_DEPTH), .WIDTH(8)) u_mem (
      .core_clk (core_clk),
      .port     (mem_bus.mem)
   );

   assign rst_all = srst | ~uart_reset_n;

   // three-stage synchroniser: a level counts once stages two and three agree
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s1_q  <= `SC_SYNC_RST;
         s2_q  <= `SC_SYNC_RST;
         s3_q  <= `SC_SYNC_RST;
         lvl_q <= `SC_SYNC_RST;
      end
      else
      begin
         s1_q  <= {io_in, aux_interrupt_input, card_b_present_pin,
                   card_a_present_pin, wr_n, rd_n, cs_n};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
      end
   end

   assign rd_act = ~lvl_q[`SC_PIN_CS] & ~lvl_q[`SC_PIN_RD];
   assign wr_act = ~lvl_q[`SC_PIN_CS] & ~lvl_q[`SC_PIN_WR];
   assign rd_end = rd_act_q & ~rd_act;
   assign wr_end = wr_act_q & ~wr_act; // end of write or of select

   // host access tracking; address and data are stable while a strobe is low
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
         addr_q   <= '0;
         wdata_q  <= `SC_DATA_RST;
      end
      else
      begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
         if (rd_act | wr_act)
         begin
            addr_q  <= addr;
            wdata_q <= wdata;
         end
      end
   end

   // fifo control writes; the shared offset only reads back status
   always_ff @(posedge core_clk)
   begin
      if (srst)
         fctl_q <= `SC_FIFO_CTRL_RST;
      else if (!uart_reset_n)
         fctl_q[`SC_FC_FTE_UPPER] <= 1'b0;
      else if (wr_end && addr_q == `SC_ADDR_MIXED)
         fctl_q <= wdata_q[6:0];
   end

   assign fifo_threshold_en = fctl_q[`SC_FC_FTE_UPPER] & threshold_enable_lower;
   assign depth_eff = (AW + 1)'(fctl_q[`SC_FC_FL_HI:`SC_FC_FL_LO]) + 1'b1;

   // fraction-of-etu divider, free running so the timeout wait stays bounded
   always_ff @(posedge core_clk)
   begin
      if (srst || sub_tick)
         frac_q <= '0;
      else
         frac_q <= frac_q + 1'b1;
   end
   assign sub_tick = (frac_q + 1'b1 >= frac_cycles);

   // control ready busy timers; two fraction ticks give one to two fractions
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         busy_q     <= '0;
         toc_wait_q <= '0;
      end
      else
      begin
         if ((rd_end || wr_end) && addr_q == `SC_ADDR_DATA)
            busy_q <= `SC_BUSY_CYCLES;
         else if (busy_q != '0)
            busy_q <= busy_q - 1'b1;
         if (wr_end && addr_q == `SC_ADDR_TIMEOUT_CFG)
            toc_wait_q <= `SC_TOC_FRACTIONS;
         else if (sub_tick && toc_wait_q != '0)
            toc_wait_q <= toc_wait_q - 1'b1;
      end
   end
   // host is trusted to poll this before the next access
   assign control_ready_flag = sync_mode | (busy_q == '0 && toc_wait_q == '0);

   // etu timing restarted by every start bit
   always_comb
   begin
      etu_len = 16'(frac_cycles) * 16'(etu_prescaler);
      if (etu_len < `SC_MIN_ETU_LEN)
         etu_len = `SC_MIN_ETU_LEN;
   end
   assign etu_tick = (cyc_q == etu_len - 1'b1);
   assign mid      = (cyc_q == (etu_len >> 1));

   always_ff @(posedge core_clk)
   begin
      if (srst || start_bit)
      begin
         cyc_q   <= '0;
         etu_n_q <= '0; // also clears the block guard flag
      end
      else if (etu_tick)
      begin
         cyc_q <= '0;
         if (etu_n_q != `SC_ETU_SAT)
            etu_n_q <= etu_n_q + 1'b1;
      end
      else
         cyc_q <= cyc_q + 1'b1;
   end

   // start conditions
   assign gap      = fail_q ? `SC_RELOAD_MIN_ETU : `SC_GUARD_ETU + {1'b0, extra_guard_etu};
   assign guard_ok = (etu_n_q >= gap);
   assign start_tx = (state_q == ST_IDLE) && tx_pend_q && guard_ok && !rst_all;
   assign io_fall  = io_prev_q & ~lvl_q[`SC_PIN_IO];
   assign start_rx = (state_q == ST_IDLE) && !tx_pend_q && !direction_tx && !sync_mode
                     && io_fall && !rst_all;
   assign retry_go = (state_q == ST_RETRY) && (etu_n_q == `SC_RETRY_ETU);
   assign start_bit = start_tx | start_rx | retry_go;
   // only one character may be loaded and only while nothing is in flight
   assign wr_data_ok = wr_end && addr_q == `SC_ADDR_DATA && direction_tx && !sync_mode
                       && state_q == ST_IDLE && !tx_pend_q;
   assign tx_ok  = (state_q == ST_TX) && etu_tick && (etu_n_q == `SC_END_ETU) && !nak_seen_q;
   assign rx_bad = par_level(rx_raw_q, convention_select) != rx_par_q;
   assign rx_store = (state_q == ST_RX) && mid && (etu_n_q == `SC_CHECK_ETU)
                     && (!rx_bad || protocol_t1);
   assign fifo_full = (count_q >= depth_eff);

   // character engine: transmit, card nak and retry, receive with nak
   always_ff @(posedge core_clk)
   begin
      parity_error_event <= 1'b0;
      last_char_clear    <= 1'b0;
      direction_clear    <= 1'b0;
      if (rst_all)
      begin
         state_q            <= ST_IDLE;
         tx_pend_q          <= 1'b0;
         tx_raw_q           <= `SC_DATA_RST;
         lct_q              <= 1'b0;
         fail_q             <= 1'b0;
         nak_seen_q         <= 1'b0;
         nak_q              <= 1'b0;
         perr_q             <= '0;
         rx_raw_q           <= `SC_DATA_RST;
         rx_par_q           <= 1'b0;
         io_prev_q          <= 1'b1;
      end
      else
      begin
         io_prev_q <= lvl_q[`SC_PIN_IO];
         if (wr_data_ok)
         begin
            tx_pend_q <= 1'b1;
            tx_raw_q  <= convention_select_xlate(wdata_q, convention_select);
            lct_q     <= last_char_flag;
         end
         unique case (state_q)
            ST_IDLE:
               if (start_tx)
               begin
                  state_q    <= ST_TX;
                  nak_seen_q <= 1'b0;
               end
               else if (start_rx)
                  state_q <= ST_RX;
            ST_TX:
            begin
               // card answers a parity error by holding the line low
               if (mid && etu_n_q == `SC_CHECK_ETU && !protocol_t1)
                  nak_seen_q <= ~lvl_q[`SC_PIN_IO];
               if (etu_tick && etu_n_q == `SC_END_ETU)
               begin
                  if (!nak_seen_q)
                  begin
                     state_q   <= ST_IDLE;
                     tx_pend_q <= 1'b0;
                     fail_q    <= 1'b0;
                     perr_q    <= '0;
                     last_char_clear <= lct_q;
                     direction_clear <= lct_q;
                  end
                  else if (perr_q < fctl_q[`SC_FC_PEC_HI:`SC_FC_PEC_LO])
                  begin
                     perr_q  <= perr_q + 1'b1;
                     state_q <= ST_RETRY;
                  end
                  else
                  begin
                     // limit reached, or zero limit: give up, host may reload
                     parity_error_event <= 1'b1;
                     state_q   <= ST_IDLE;
                     tx_pend_q <= 1'b0;
                     fail_q    <= 1'b1;
                     perr_q    <= '0;
                  end
               end
            end
            ST_RETRY:
               if (retry_go)
               begin
                  state_q    <= ST_TX;
                  nak_seen_q <= 1'b0;
               end
            ST_RX:
            begin
               if (mid && etu_n_q != '0 && etu_n_q < `SC_PARITY_ETU)
                  rx_raw_q <= {lvl_q[`SC_PIN_IO], rx_raw_q[7:1]};
               if (mid && etu_n_q == `SC_PARITY_ETU)
                  rx_par_q <= lvl_q[`SC_PIN_IO];
               if (mid && etu_n_q == `SC_CHECK_ETU)
               begin
                  if (!rx_bad)
                     perr_q <= '0;
                  else if (protocol_t1)
                     parity_error_event <= 1'b1;
                  else
                  begin
                     nak_q <= 1'b1;
                     if (perr_q == fctl_q[`SC_FC_PEC_HI:`SC_FC_PEC_LO])
                     begin
                        parity_error_event <= 1'b1;
                        perr_q <= '0;
                     end
                     else
                        perr_q <= perr_q + 1'b1;
                  end
               end
               if (mid && etu_n_q == `SC_END_ETU)
               begin
                  nak_q   <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // synchronous mode: only bit zero reaches the line
   always_ff @(posedge core_clk)
   begin
      if (rst_all)
         sync_bit_q <= 1'b1;
      else if (sync_mode && wr_end && addr_q == `SC_ADDR_DATA)
         sync_bit_q <= wdata_q[0];
   end

   // open-drain card line: we only ever pull it low
   always_comb
   begin
      io_out  = 1'b0;
      io_oe_n = 1'b1;
      if (sync_mode)
         io_oe_n = sync_bit_q;
      else if (state_q == ST_TX && etu_n_q < `SC_CHECK_ETU)
      begin
         unique case (etu_n_q)
            9'd0:    io_oe_n = 1'b0;
            `SC_PARITY_ETU: io_oe_n = par_level(tx_raw_q, convention_select);
            default: io_oe_n = tx_raw_q[etu_n_q[2:0] - 3'd1];
         endcase
      end
      else if (nak_q)
         io_oe_n = 1'b0;
   end

   // receive fifo; t0 characters with bad parity never get here
   assign rd_pop = rd_end && addr_q == `SC_ADDR_DATA && !sync_mode && !direction_tx
                   && count_q != '0;
   assign mem_bus.wr_en   = rx_store && !fifo_full;
   assign mem_bus.wr_addr = wptr_q;
   assign mem_bus.wr_data = convention_select_xlate(rx_raw_q, convention_select);
   assign mem_bus.rd_addr = rptr_q; // head slot, oldest character

   always_ff @(posedge core_clk)
   begin
      overrun_event <= rx_store && fifo_full; // new character is dropped
      if (rst_all)
      begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
      end
      else
      begin
         if (mem_bus.wr_en)
            wptr_q <= wptr_q + 1'b1;
         if (rd_pop)
            rptr_q <= rptr_q + 1'b1;
         count_q <= count_q + (AW + 1)'(mem_bus.wr_en) - (AW + 1)'(rd_pop);
      end
   end

   // transmit empty / receive full: set beats clear in the same cycle
   always_ff @(posedge core_clk)
   begin
      dir_q <= direction_tx;
      if (rst_all)
         tbe_q <= 1'b0;
      else if ((direction_tx && !dir_q)
               || (tx_ok && !lct_q)
               || (mem_bus.wr_en && count_q + 1'b1 == depth_eff))
         tbe_q <= 1'b1;
      else if ((!direction_tx && dir_q) || wr_data_ok || rd_pop || (tx_ok && lct_q))
         tbe_q <= 1'b0;
   end
   assign tx_empty_rx_full_flag = tbe_q;

   // host read data, captured while the read strobe is low
   always_ff @(posedge core_clk)
   begin
      if (srst)
         rdata <= `SC_DATA_RST;
      else if (rd_act)
      begin
         unique case (addr)
            `SC_ADDR_MIXED:
               rdata <= {clock_switched_in,
                         count_q == '0,
                         etu_n_q >= (protocol_t1 ? `SC_BGT_T1_ETU
                                                 : `SC_BGT_T0_ETU),
                         control_ready_flag,
                         lvl_q[`SC_PIN_PRES_B], lvl_q[`SC_PIN_PRES_A],
                         lvl_q[`SC_PIN_AUX],
                         tbe_q};
            `SC_ADDR_DATA:
               rdata <= sync_mode ? {7'h00, lvl_q[`SC_PIN_IO]} : mem_bus.rd_data;
            default:
               rdata <= 8'h00;
         endcase
      end
   end
endmodule // smart_card_uart_status_fifo
`default_nettype wire

// ### tb/sc_card_model.sv
// card model: open-drain io line with pull-up, sends one character per call
`timescale 1ns/100ps
`default_nettype none
module sc_card_model (
   // clock and device drive
   input  wire logic core_clk,
   input  wire logic dev_oe_n,
   // resolved line level
   output logic      io
);
   logic card_low = 1'b0; // card pulls the line low
   assign io = !(card_low || !dev_oe_n); // pull-up wins when nobody drives
   // 8 clocks per etu: start, 8 data, parity, then 3 etu of released line
   task automatic send(input logic [7:0] c, input logic inv, input logic bad);
      logic [9:0] f;
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++)
         f[i+1] = inv ? ~c[7-i] : c[i];
      f[9] = inv ? ~(^c ^ bad) : (^c ^ bad);
      for (int i = 0; i < 13; i++)
      begin
         @(posedge core_clk);
         #2 card_low = (i < 10) ? !f[i] : 1'b0;
         repeat (7) @(posedge core_clk);
      end
   endtask
endmodule // sc_card_model
`default_nettype wire

// ### tb/sc_uart_props.sv
// concurrent checks on the status, fifo and data-buffer ports
`timescale 1ns/100ps
`default_nettype none
module sc_uart_props (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       srst,
   // watched ports
   input wire logic [7:0] rdata,
   input wire logic       uart_reset_n,
   input wire logic       direction_tx,
   input wire logic       protocol_t1,
   input wire logic       threshold_enable_lower,
   input wire logic       io_oe_n,
   input wire logic       last_char_clear,
   input wire logic       direction_clear,
   input wire logic       parity_error_event,
   input wire logic       fifo_threshold_en,
   input wire logic       tx_empty_rx_full_flag
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   a_rst_quiet: assert property ($fell(srst) |-> rdata == 8'h00 && io_oe_n)
      else $error("outputs busy after reset");
   a_thr_both: assert property (fifo_threshold_en |-> threshold_enable_lower)
      else $error("threshold on with one enable");
   a_tbe_urst: assert property (!uart_reset_n [*2] |-> !tx_empty_rx_full_flag)
      else $error("flag set in uart reset");
   a_tbe_dir_set: assert property (uart_reset_n && $rose(direction_tx) |-> ##[1:2]
      tx_empty_rx_full_flag)
      else $error("flag not set on transmit mode");
   a_tbe_dir_clr: assert property ($fell(direction_tx) |-> ##[1:2] !tx_empty_rx_full_flag)
      else $error("flag not cleared on receive mode");
   a_t1_no_nak: assert property (protocol_t1 && !direction_tx |=> io_oe_n)
      else $error("line pulled in t1 receive");
   a_lct_pair: assert property (last_char_clear |-> direction_clear ##[0:1]
      !tx_empty_rx_full_flag)
      else $error("last char return incomplete");
   a_pe_pulse: assert property (parity_error_event |=> !parity_error_event)
      else $error("parity pulse too long");
   c_dir: cover property ($rose(tx_empty_rx_full_flag));
   c_pe: cover property (parity_error_event);
   c_lct: cover property (last_char_clear);
endmodule // sc_uart_props
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the smart-card status, fifo and data-buffer section
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // signals carry the design port names
   logic core_clk = 1'b0, srst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, seen;
   logic uart_reset_n = 1'b1, direction_tx = 1'b0, last_char_flag = 1'b0;
   logic protocol_t1 = 1'b0, sync_mode = 1'b0, convention_select = 1'b1;
   logic threshold_enable_lower = 1'b0, clock_switched_in = 1'b0, aux_interrupt_input = 1'b0;
   logic card_a_present_pin = 1'b0, card_b_present_pin = 1'b0, io_in, io_out, io_oe_n;
   logic last_char_clear, direction_clear, parity_error_event, overrun_event;
   logic fifo_threshold_en, tx_empty_rx_full_flag;
   logic [7:0] etu_prescaler = 8'h04, frac_cycles = 8'h02, extra_guard_etu = 8'h00;
   logic [31:0] rnd = 32'h970b; // stimulus lfsr
   logic [15:0] exp_q[$];       // expected value, mask
   int error_cnt = 0, n_compared = 0;
   int ev_cnt[3] = '{0, 0, 0};  // parity, overrun, last char pulses
   event got;
   always #12.5 core_clk = ~core_clk;
   smart_card_uart_status_fifo smart_card_uart_status_fifo_inst (.*);
   sc_card_model sc_card_model_inst (.core_clk, .dev_oe_n(io_oe_n), .io(io_in));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // strobes held 8 cycles for the synchronisers, then a fixed 12 cycles cover ready
   task automatic host(input logic rd, input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #2 {addr, wdata, cs_n, rd_n, wr_n} = {a, d, 1'b0, !rd, rd};
      repeat (8) @(posedge core_clk);
      #2 seen = rdata;
      {cs_n, rd_n, wr_n} = 3'b111;
      if (rd)
         -> got;
      repeat (12) @(posedge core_clk); // no access while ready is low
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back({e, m});
      host(1'b1, a, 8'h00);
   endtask
   // oldest note against each captured read
   always @(got)
   begin
      check("read", seen & exp_q[0][7:0], exp_q[0][15:8] & exp_q[0][7:0]);
      void'(exp_q.pop_front());
   end
   always @(posedge core_clk)
      ev_cnt <= '{ev_cnt[0] + (parity_error_event === 1'b1),
         ev_cnt[1] + (overrun_event === 1'b1), ev_cnt[2] + (last_char_clear === 1'b1)};
   initial
   begin
      repeat (8) @(posedge core_clk);
      #2 srst = 1'b0;
      repeat (4)
      begin
         #2 rnd = lfsr(rnd);
         {clock_switched_in, card_a_present_pin} = rnd[3:2];
         {card_b_present_pin, aux_interrupt_input} = rnd[1:0];
         rd(4'hc, {rnd[3], 3'b101, rnd[1], rnd[2], rnd[0], 1'b0}, 8'hff);
      end
      host(1'b0, 4'hc, 8'h01); // depth two, limit zero
      sc_card_model_inst.send(8'ha5, 1'b0, 1'b0);
      #2 convention_select = 1'b0;
      sc_card_model_inst.send(8'h3c, 1'b1, 1'b0);
      sc_card_model_inst.send(8'h77, 1'b1, 1'b0);
      check("ovr", 8'(ev_cnt[1]), 8'h01);
      rd(4'hc, 8'h01, 8'h41);
      rd(4'hd, 8'ha5, 8'hff);
      rd(4'hd, 8'h3c, 8'hff);
      rd(4'hc, 8'h40, 8'h41);
      #2 convention_select = 1'b1;
      sc_card_model_inst.send(8'h11, 1'b0, 1'b1);
      check("pe_t0", 8'(ev_cnt[0]), 8'h01);
      rd(4'hc, 8'h40, 8'h40);
      #2 protocol_t1 = 1'b1;
      sc_card_model_inst.send(8'h22, 1'b0, 1'b1);
      check("pe_t1", 8'(ev_cnt[0]), 8'h02);
      rd(4'hd, 8'h22, 8'hff);
      #2 protocol_t1 = 1'b0;
      threshold_enable_lower = 1'b1;
      host(1'b0, 4'hc, 8'h09);
      check("thr", {7'h00, fifo_threshold_en}, 8'h01);
      #2 direction_tx = 1'b1;
      rd(4'hc, 8'h01, 8'h01);
      host(1'b0, 4'hd, 8'h5a);
      rd(4'hc, 8'h00, 8'h21);
      repeat (120) @(posedge core_clk);
      rd(4'hc, 8'h21, 8'h21);
      #2 uart_reset_n = 1'b0;
      repeat (4) @(posedge core_clk);
      #2 uart_reset_n = 1'b1;
      rd(4'hc, 8'h00, 8'h01);
      #2 last_char_flag = 1'b1;
      host(1'b0, 4'hd, 8'h5b);
      repeat (120) @(posedge core_clk);
      check("lct", 8'(ev_cnt[2]), 8'h01);
      rd(4'hc, 8'h00, 8'h01);
      #2 {direction_tx, last_char_flag, sync_mode} = 3'b001;
      repeat (4) @(posedge core_clk);
      host(1'b0, 4'hd, 8'hfe);
      rd(4'hd, 8'h00, 8'hff);
      final_report();
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      error_cnt++;
      final_report();
   end
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
endmodule // testbench
bind smart_card_uart_status_fifo sc_uart_props sc_uart_props_inst (.core_clk, .srst, .rdata,
   .uart_reset_n, .direction_tx, .protocol_t1, .threshold_enable_lower, .io_oe_n,
   .last_char_clear, .direction_clear, .parity_error_event, .fifo_threshold_en,
   .tx_empty_rx_full_flag);
`default_nettype wire
